// ==== io_register_space_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "io_space_defines.svh"
module io_register_space_decoder (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  input  wire io_space_pkg::io_req_t req_i,
  input  wire logic [7:0]           pin_b_i,
  input  wire logic [7:0]           pin_c_i,
  input  wire logic [7:0]           pin_d_i,
  input  wire logic [7:0]           conv_low_i,
  input  wire logic [7:0]           conv_high_i,
  input  wire logic [7:0]           flag_set_t0_i,
  input  wire logic [7:0]           flag_set_t1_i,
  input  wire logic [7:0]           flag_set_t2_i,
  input  wire logic [7:0]           flag_set_pc_i,
  input  wire logic [7:0]           flag_set_ex_i,
  output io_space_pkg::io_rsp_t     rsp_o,
  output logic                      skip_o,
  output logic [7:0]                dir_b_o,
  output logic [7:0]                out_b_o,
  output logic [7:0]                dir_c_o,
  output logic [7:0]                out_c_o,
  output logic [7:0]                dir_d_o,
  output logic [7:0]                out_d_o,
  output logic [7:0]                ex_mask_o,
  output logic [7:0]                flags_t0_o,
  output logic [7:0]                flags_ex_o
);
  // storage indexed by data-space address; only mapped entries are kept
  logic [7:0]            mem_reg  [0:255];
  logic [7:0]            mem_next [0:255];
  logic [255:0]          mapped;
  logic [255:0]          w1c;
  logic [255:0]          ro;
  logic [7:0]            w1c_mask [0:255];
  logic [7:0]            setv     [0:255];
  logic [7:0]            daddr;
  logic                  legal;
  logic                  is_write;
  logic                  is_bit;
  logic [7:0]            cur;
  logic [7:0]            bmask;
  io_space_pkg::io_rsp_t rsp_reg;
  io_space_pkg::io_rsp_t rsp_next;
  logic                  skip_reg;
  logic                  skip_next;

  function automatic logic is_map(input logic [7:0] a);
    case (a)
      `ADDR_PIN_B, `ADDR_DIR_B, `ADDR_OUT_B, `ADDR_PIN_C, `ADDR_DIR_C,
      `ADDR_OUT_C, `ADDR_PIN_D, `ADDR_DIR_D, `ADDR_OUT_D,
      `ADDR_T0_FLAGS, `ADDR_T1_FLAGS, `ADDR_T2_FLAGS, `ADDR_PC_FLAGS,
      `ADDR_EX_FLAGS, `ADDR_EX_MASK, `ADDR_SCRATCH0, `ADDR_NV_CTRL,
      `ADDR_NV_DATA, `ADDR_NV_ADDRL, `ADDR_NV_ADDRH, `ADDR_PRESCALE,
      `ADDR_T0_CTRLA, `ADDR_T0_CTRLB, `ADDR_T0_CMPA, `ADDR_T0_CMPB,
      `ADDR_SCRATCH1, `ADDR_SCRATCH2, `ADDR_SPI_CTRL, `ADDR_SPI_STAT,
      `ADDR_CMP_CTRL, `ADDR_SLEEP, `ADDR_RST_CAUSE, `ADDR_CORE_CTRL,
      `ADDR_SELF_PROG, `ADDR_SP_LOW, `ADDR_SP_HIGH, `ADDR_CORE_FLAGS,
      `ADDR_WDOG, `ADDR_POWER, `ADDR_PC_MASK0, `ADDR_PC_MASK1,
      `ADDR_PC_MASK2, `ADDR_T0_MASK, `ADDR_T1_MASK, `ADDR_T2_MASK,
      `ADDR_CONV_LOW, `ADDR_CONV_HIGH: is_map = 1'b1;
      default: is_map = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] flag_bits(input logic [7:0] a);
    case (a)
      `ADDR_T0_FLAGS: flag_bits = `FLAGS_T0_BITS;
      `ADDR_T1_FLAGS: flag_bits = `FLAGS_T1_BITS;
      `ADDR_T2_FLAGS: flag_bits = `FLAGS_T2_BITS;
      `ADDR_PC_FLAGS: flag_bits = `FLAGS_PC_BITS;
      `ADDR_EX_FLAGS: flag_bits = `FLAGS_EX_BITS;
      default:        flag_bits = 8'h00;
    endcase
  endfunction

  // io instructions add the offset, data accesses use the address as is
  always_comb begin
    daddr = req_i.addr;
    legal = 1'b0;
    case (req_i.op)
      io_space_pkg::OP_IN, io_space_pkg::OP_OUT: begin
        daddr = 8'(req_i.addr + `IO_DATA_OFFSET);
        legal = (req_i.addr <= `IO_DIRECT_LAST);
      end
      io_space_pkg::OP_SET, io_space_pkg::OP_CLEAR,
      io_space_pkg::OP_TEST: begin
        daddr = 8'(req_i.addr + `IO_DATA_OFFSET);
        legal = (req_i.addr <= `IO_BIT_LAST);
      end
      io_space_pkg::OP_LOAD, io_space_pkg::OP_STORE: begin
        legal = (req_i.addr >= `IO_DATA_OFFSET);
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end

  always_comb begin
    is_write = legal && (req_i.op == io_space_pkg::OP_OUT ||
                         req_i.op == io_space_pkg::OP_STORE);
    is_bit   = legal && (req_i.op == io_space_pkg::OP_SET ||
                         req_i.op == io_space_pkg::OP_CLEAR);
    bmask    = 8'h01 << req_i.bit_sel;
    cur      = mapped[daddr] ? mem_reg[daddr] : 8'h00;
  end

  // hardware flag sets are masked to the defined flag bits of their entries
  always_comb begin
    for (int k = 0; k < 256; k++) begin
      setv[k] = 8'h00;
    end
    setv[`ADDR_T0_FLAGS] = flag_set_t0_i & `FLAGS_T0_BITS;
    setv[`ADDR_T1_FLAGS] = flag_set_t1_i & `FLAGS_T1_BITS;
    setv[`ADDR_T2_FLAGS] = flag_set_t2_i & `FLAGS_T2_BITS;
    setv[`ADDR_PC_FLAGS] = flag_set_pc_i & `FLAGS_PC_BITS;
    setv[`ADDR_EX_FLAGS] = flag_set_ex_i & `FLAGS_EX_BITS;
  end

  genvar g;
  generate
    for (g = 0; g < 256; g++) begin : g_entry
      localparam logic [7:0] A = 8'(g);
      assign mapped[g]   = is_map(A);
      assign w1c_mask[g] = flag_bits(A);
      assign w1c[g]      = (flag_bits(A) != 8'h00);
      assign ro[g]       = (A == `ADDR_PIN_B) || (A == `ADDR_PIN_C) ||
                           (A == `ADDR_PIN_D) || (A == `ADDR_CONV_LOW) ||
                           (A == `ADDR_CONV_HIGH);
      always_comb begin
        mem_next[g] = mem_reg[g];
        if (!mapped[g]) begin
          mem_next[g] = 8'h00;
        end else if (ro[g]) begin
          mem_next[g] = mem_reg[g];
        end else if (daddr == A && is_write) begin
          if (w1c[g]) begin
            mem_next[g] = mem_reg[g] & ~(req_i.wdata & w1c_mask[g]);
          end else begin
            mem_next[g] = req_i.wdata;
          end
        end else if (daddr == A && is_bit) begin
          // only the addressed bit moves, so pending flags survive
          if (w1c[g]) begin
            mem_next[g] = (req_i.op == io_space_pkg::OP_SET) ?
                          (mem_reg[g] & ~(bmask & w1c_mask[g])) :
                          mem_reg[g];
          end else if (req_i.op == io_space_pkg::OP_SET) begin
            mem_next[g] = mem_reg[g] | bmask;
          end else begin
            mem_next[g] = mem_reg[g] & ~bmask;
          end
        end
        // hardware set wins over a same-cycle clear
        mem_next[g] = mem_next[g] | setv[g];
      end
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          mem_reg[g] <= `REG_RESET;
        end else begin
          if (A == `ADDR_PIN_B) begin
            mem_reg[g] <= pin_b_i;
          end else if (A == `ADDR_PIN_C) begin
            mem_reg[g] <= pin_c_i;
          end else if (A == `ADDR_PIN_D) begin
            mem_reg[g] <= pin_d_i;
          end else if (A == `ADDR_CONV_LOW) begin
            mem_reg[g] <= conv_low_i;
          end else if (A == `ADDR_CONV_HIGH) begin
            mem_reg[g] <= conv_high_i;
          end else begin
            mem_reg[g] <= mem_next[g];
          end
        end
      end
    end
  endgenerate

  always_comb begin
    rsp_next  = '0;
    skip_next = 1'b0;
    if (legal && mapped[daddr]) begin
      rsp_next.hit = 1'b1;
      if (req_i.op == io_space_pkg::OP_IN ||
          req_i.op == io_space_pkg::OP_LOAD) begin
        rsp_next.rdata = cur;
      end
      if (req_i.op == io_space_pkg::OP_TEST) begin
        rsp_next.bit_val = cur[req_i.bit_sel];
        skip_next        = cur[req_i.bit_sel];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_reg  <= '0;
      skip_reg <= 1'b0;
    end else begin
      rsp_reg  <= rsp_next;
      skip_reg <= skip_next;
    end
  end

  assign rsp_o      = rsp_reg;
  assign skip_o     = skip_reg;
  assign dir_b_o    = mem_reg[`ADDR_DIR_B];
  assign out_b_o    = mem_reg[`ADDR_OUT_B];
  assign dir_c_o    = mem_reg[`ADDR_DIR_C];
  assign out_c_o    = mem_reg[`ADDR_OUT_C];
  assign dir_d_o    = mem_reg[`ADDR_DIR_D];
  assign out_d_o    = mem_reg[`ADDR_OUT_D];
  assign ex_mask_o  = mem_reg[`ADDR_EX_MASK];
  assign flags_t0_o = mem_reg[`ADDR_T0_FLAGS];
  assign flags_ex_o = mem_reg[`ADDR_EX_FLAGS];

  sequence s_bit_clear_on_low;
    req_i.op == io_space_pkg::OP_CLEAR && req_i.addr == 8'h05;
  endsequence

  default clocking assert_clk @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_OUT_WRITE: assert property (
    req_i.op == io_space_pkg::OP_OUT && req_i.addr == 8'h05
    |=> out_b_o == $past(req_i.wdata))
    else $error("io write did not land");
  AST_STORE_ALIAS: assert property (
    req_i.op == io_space_pkg::OP_STORE && req_i.addr == 8'h25
    |=> out_b_o == $past(req_i.wdata))
    else $error("data alias write failed");
  AST_EXT_NO_IO: assert property (
    req_i.op == io_space_pkg::OP_IN && req_i.addr > 8'h3F |=> !rsp_o.hit)
    else $error("io instruction hit beyond window");
  AST_BIT_RANGE: assert property (
    (req_i.op == io_space_pkg::OP_SET ||
     req_i.op == io_space_pkg::OP_CLEAR ||
     req_i.op == io_space_pkg::OP_TEST) && req_i.addr > 8'h1F
    |=> !rsp_o.hit)
    else $error("bit access outside low range");
  AST_BIT_CLEAR: assert property (
    s_bit_clear_on_low |=> out_b_o == ($past(out_b_o) &
      ~(8'h01 << $past(req_i.bit_sel))))
    else $error("bit clear wrong");
  AST_SKIP: assert property (
    req_i.op == io_space_pkg::OP_TEST && req_i.addr == 8'h05
    |=> skip_o == $past(out_b_o[req_i.bit_sel]))
    else $error("skip flag wrong");
  AST_W1C: assert property (
    req_i.op == io_space_pkg::OP_OUT && req_i.addr == 8'h15 &&
    flag_set_t0_i == 8'h00
    |=> flags_t0_o == ($past(flags_t0_o) & ~$past(req_i.wdata)))
    else $error("flag clear wrong");
  AST_BIT_KEEPS: assert property (
    req_i.op == io_space_pkg::OP_CLEAR && req_i.addr == 8'h1C
    |=> (flags_ex_o & $past(flags_ex_o)) == $past(flags_ex_o))
    else $error("bit clear disturbed flags");
  AST_RSV_ZERO: assert property (
    req_i.op == io_space_pkg::OP_LOAD && req_i.addr == 8'h2C
    |=> rsp_o.rdata == 8'h00 && !rsp_o.hit)
    else $error("reserved read not zero");
  AST_RESET_IDLE: assert property (
    $rose(rst_n_i) |-> !rsp_o.hit && !skip_o)
    else $error("select active after reset");
endmodule
`default_nettype wire

// ==== io_space_defines.svh ====
// Behaviour
// - low registers support single bit set/clear
// - low registers support bit test and skip
// - status flags clear on written one
// - bit operations touch only addressed bit
// - bit operations only for addresses 0x00-0x1F
// - io instructions use addresses 0x00-0x3F
// - data address equals io address plus 0x20
// - extended region 0x60-0xFF data access only
`ifndef IO_SPACE_DEFINES_SVH
`define IO_SPACE_DEFINES_SVH
`define IO_DATA_OFFSET   8'h20
`define IO_DIRECT_LAST   8'h3F
`define IO_BIT_LAST      8'h1F
`define EXT_FIRST        8'h60
`define EXT_LAST         8'hFF
`define ADDR_PIN_B       8'h23
`define ADDR_DIR_B       8'h24
`define ADDR_OUT_B       8'h25
`define ADDR_PIN_C       8'h26
`define ADDR_DIR_C       8'h27
`define ADDR_OUT_C       8'h28
`define ADDR_PIN_D       8'h29
`define ADDR_DIR_D       8'h2A
`define ADDR_OUT_D       8'h2B
`define ADDR_T0_FLAGS    8'h35
`define ADDR_T1_FLAGS    8'h36
`define ADDR_T2_FLAGS    8'h37
`define ADDR_PC_FLAGS    8'h3B
`define ADDR_EX_FLAGS    8'h3C
`define ADDR_EX_MASK     8'h3D
`define ADDR_SCRATCH0    8'h3E
`define ADDR_NV_CTRL     8'h3F
`define ADDR_NV_DATA     8'h40
`define ADDR_NV_ADDRL    8'h41
`define ADDR_NV_ADDRH    8'h42
`define ADDR_PRESCALE    8'h43
`define ADDR_T0_CTRLA    8'h44
`define ADDR_T0_CTRLB    8'h45
`define ADDR_T0_CMPA     8'h47
`define ADDR_T0_CMPB     8'h48
`define ADDR_SCRATCH1    8'h4A
`define ADDR_SCRATCH2    8'h4B
`define ADDR_SPI_CTRL    8'h4C
`define ADDR_SPI_STAT    8'h4D
`define ADDR_CMP_CTRL    8'h50
`define ADDR_SLEEP       8'h53
`define ADDR_RST_CAUSE   8'h54
`define ADDR_CORE_CTRL   8'h55
`define ADDR_SELF_PROG   8'h57
`define ADDR_SP_LOW      8'h5D
`define ADDR_SP_HIGH     8'h5E
`define ADDR_CORE_FLAGS  8'h5F
`define ADDR_WDOG        8'h60
`define ADDR_POWER       8'h64
`define ADDR_PC_MASK0    8'h6B
`define ADDR_PC_MASK1    8'h6C
`define ADDR_PC_MASK2    8'h6D
`define ADDR_T0_MASK     8'h6E
`define ADDR_T1_MASK     8'h6F
`define ADDR_T2_MASK     8'h70
`define ADDR_CONV_LOW    8'h78
`define ADDR_CONV_HIGH   8'h79
`define FLAGS_T0_BITS    8'h07
`define FLAGS_T1_BITS    8'h27
`define FLAGS_T2_BITS    8'h07
`define FLAGS_PC_BITS    8'h07
`define FLAGS_EX_BITS    8'h03
`define REG_RESET        8'h00
`endif

// ==== io_space_pkg.sv ====
package io_space_pkg;
  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_IN    = 3'b001,
    OP_OUT   = 3'b010,
    OP_LOAD  = 3'b011,
    OP_STORE = 3'b100,
    OP_SET   = 3'b101,
    OP_CLEAR = 3'b110,
    OP_TEST  = 3'b111
  } io_op_t;
  typedef struct packed {
    io_op_t     op;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] bit_sel;
  } io_req_t;
  typedef struct packed {
    logic [7:0] rdata;
    logic       bit_val;
    logic       hit;
  } io_rsp_t;
endpackage

// ==== core_access_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module core_access_model (
  input  wire logic                  mclk_i,
  input  wire io_space_pkg::io_rsp_t rsp_i,
  input  wire logic                  skip_i,
  output io_space_pkg::io_req_t      req_o
);
  initial req_o = '0;
  // one access per call; an idle cycle follows so each answer stands alone
  task automatic access(input io_space_pkg::io_op_t   op,
                        input logic [7:0]             a,
                        input logic [7:0]             d,
                        input logic [2:0]             b,
                        output io_space_pkg::io_rsp_t rsp,
                        output logic                  skip);
    logic [7:0] da;
    logic       wr;
    da = a + 8'h20;
    if (op inside {io_space_pkg::OP_LOAD, io_space_pkg::OP_STORE})
      da = a;
    wr = op inside {io_space_pkg::OP_OUT, io_space_pkg::OP_STORE};
    case (da)
      8'h27, 8'h28: d[7] = 1'b0;
      8'h3C, 8'h3D: d[7:2] = 6'h00;
      default: ;
    endcase
    // a write aimed at a hole from 0x20 to 0x3A is turned into OP_NONE before it reaches the bus
    if (wr && da inside {[8'h20:8'h22], [8'h2C:8'h34], [8'h38:8'h3A]})
      op = io_space_pkg::OP_NONE;
    @(posedge mclk_i);
    req_o <= '{op: op, addr: a, wdata: d, bit_sel: b};
    @(posedge mclk_i);
    req_o <= '0;
    #1;
    rsp = rsp_i;
    skip = skip_i;
  endtask
endmodule
`default_nettype wire

// ==== io_register_space_decoder_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module io_register_space_decoder_test;
  logic                  mclk_i;
  logic                  rst_n_i;
  io_space_pkg::io_req_t req;
  io_space_pkg::io_rsp_t rsp;
  io_space_pkg::io_rsp_t got;
  logic                  skip;
  logic                  got_skip;
  logic [7:0]            pin_b, pin_c, pin_d, cv_lo, cv_hi;
  logic [7:0]            fs_t0, fs_t1, fs_t2, fs_pc, fs_ex;
  logic [7:0]            dir_b, out_b, dir_c, out_c, dir_d, out_d;
  logic [7:0]            ex_mask, fl_t0, fl_ex;
  logic [7:0]            a;
  int                    n_errors;
  int                    total_checks;
  logic [7:0]            rw_tab [10] = '{8'h24, 8'h25, 8'h2A, 8'h2B, 8'h3E,
                                         8'h4A, 8'h5F, 8'h64, 8'h6B, 8'h70};

  io_register_space_decoder uut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req),
    .pin_b_i(pin_b), .pin_c_i(pin_c), .pin_d_i(pin_d),
    .conv_low_i(cv_lo), .conv_high_i(cv_hi),
    .flag_set_t0_i(fs_t0), .flag_set_t1_i(fs_t1), .flag_set_t2_i(fs_t2),
    .flag_set_pc_i(fs_pc), .flag_set_ex_i(fs_ex),
    .rsp_o(rsp), .skip_o(skip), .dir_b_o(dir_b), .out_b_o(out_b),
    .dir_c_o(dir_c), .out_c_o(out_c), .dir_d_o(dir_d), .out_d_o(out_d),
    .ex_mask_o(ex_mask), .flags_t0_o(fl_t0), .flags_ex_o(fl_ex)
  );
  core_access_model core (
    .mclk_i(mclk_i), .rsp_i(rsp), .skip_i(skip), .req_o(req)
  );

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic results();
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got_v, input logic [7:0] exp);
    total_checks++;
    if (got_v !== exp) begin
      n_errors++;
      $display("wrong value at %0t: byte %h, expected %h", $time, got_v, exp);
    end
  endtask

  task automatic check_bit(input logic got_v, input logic exp);
    total_checks++;
    if (got_v !== exp) begin
      n_errors++;
      $display("wrong value at %0t: bit %b, expected %b", $time, got_v, exp);
    end
  endtask

  // hit is compared on every access, read data only on reads
  task automatic xfer(input io_space_pkg::io_op_t o, input logic [7:0] ad,
                      input logic [7:0] d, input logic [2:0] b,
                      input logic [7:0] er, input logic eh);
    core.access(o, ad, d, b, got, got_skip);
    check_bit(got.hit, eh);
    if (o inside {io_space_pkg::OP_IN, io_space_pkg::OP_LOAD})
      check_byte(got.rdata, er);
  endtask

  initial begin
    repeat (4000) @(posedge mclk_i);
    n_errors++;
    results();
  end

  initial begin
    n_errors = 0;
    total_checks = 0;
    rst_n_i = 1'b0;
    {pin_b, pin_c, pin_d, cv_lo, cv_hi} = {8'h3C, 8'h5A, 8'h81, 8'h96, 8'h02};
    {fs_t0, fs_t1, fs_t2, fs_pc, fs_ex} = '0;
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    #1;
    check_byte(out_b, 8'h00);
    check_bit(rsp.hit, 1'b0);
    foreach (rw_tab[i]) begin
      a = rw_tab[i];
      xfer(io_space_pkg::OP_LOAD, a, 0, 0, 8'h00, 1);
      xfer(io_space_pkg::OP_STORE, a, a ^ 8'hC3, 0, 0, 1);
      xfer(io_space_pkg::OP_LOAD, a, 0, 0, a ^ 8'hC3, 1);
      if (a < 8'h60)
        xfer(io_space_pkg::OP_IN, a - 8'h20, 0, 0, a ^ 8'hC3, 1);
      else
        xfer(io_space_pkg::OP_IN, a - 8'h20, 0, 0, 8'h00, 0);
    end
    check_byte(dir_b, 8'h24 ^ 8'hC3);
    check_byte(out_d, 8'h2B ^ 8'hC3);
    check_byte(dir_d, 8'h2A ^ 8'hC3);
    xfer(io_space_pkg::OP_OUT, 8'h07, 8'hFE, 0, 0, 1);
    check_byte(dir_c, 8'h7E);
    xfer(io_space_pkg::OP_STORE, 8'h28, 8'h35, 0, 0, 1);
    check_byte(out_c, 8'h35);
    xfer(io_space_pkg::OP_OUT, 8'h44, 8'h11, 0, 0, 0);
    xfer(io_space_pkg::OP_LOAD, 8'h64, 0, 0, 8'h64 ^ 8'hC3, 1);
    xfer(io_space_pkg::OP_OUT, 8'h05, 8'hA5, 0, 0, 1);
    check_byte(out_b, 8'hA5);
    xfer(io_space_pkg::OP_SET, 8'h05, 0, 6, 0, 1);
    check_byte(out_b, 8'hE5);
    xfer(io_space_pkg::OP_CLEAR, 8'h05, 0, 0, 0, 1);
    check_byte(out_b, 8'hE4);
    xfer(io_space_pkg::OP_TEST, 8'h05, 0, 2, 0, 1);
    check_bit(got_skip, 1'b1);
    check_bit(got.bit_val, 1'b1);
    xfer(io_space_pkg::OP_TEST, 8'h05, 0, 0, 0, 1);
    check_bit(got_skip, 1'b0);
    xfer(io_space_pkg::OP_CLEAR, 8'h2A, 0, 0, 0, 0);
    xfer(io_space_pkg::OP_LOAD, 8'h4A, 0, 0, 8'h89, 1);
    xfer(io_space_pkg::OP_TEST, 8'h2A, 0, 0, 0, 0);
    xfer(io_space_pkg::OP_SET, 8'h1D, 0, 1, 0, 1);
    check_byte(ex_mask, 8'h02);
    @(posedge mclk_i);
    {fs_t0, fs_t1, fs_t2, fs_pc, fs_ex} <= {5{8'hFF}};
    @(posedge mclk_i);
    {fs_t0, fs_t1, fs_t2, fs_pc, fs_ex} <= '0;
    #1;
    check_byte(fl_t0, 8'h07);
    check_byte(fl_ex, 8'h03);
    xfer(io_space_pkg::OP_LOAD, 8'h36, 0, 0, 8'h27, 1);
    xfer(io_space_pkg::OP_LOAD, 8'h3B, 0, 0, 8'h07, 1);
    xfer(io_space_pkg::OP_OUT, 8'h15, 8'h02, 0, 0, 1);
    check_byte(fl_t0, 8'h05);
    xfer(io_space_pkg::OP_OUT, 8'h15, 8'h00, 0, 0, 1);
    check_byte(fl_t0, 8'h05);
    xfer(io_space_pkg::OP_SET, 8'h1C, 0, 0, 0, 1);
    check_byte(fl_ex, 8'h02);
    xfer(io_space_pkg::OP_CLEAR, 8'h1C, 0, 1, 0, 1);
    check_byte(fl_ex, 8'h02);
    xfer(io_space_pkg::OP_OUT, 8'h03, 8'hFF, 0, 0, 1);
    xfer(io_space_pkg::OP_IN, 8'h03, 0, 0, 8'h3C, 1);
    xfer(io_space_pkg::OP_LOAD, 8'h26, 0, 0, 8'h5A, 1);
    xfer(io_space_pkg::OP_IN, 8'h09, 0, 0, 8'h81, 1);
    xfer(io_space_pkg::OP_LOAD, 8'h78, 0, 0, 8'h96, 1);
    xfer(io_space_pkg::OP_LOAD, 8'h79, 0, 0, 8'h02, 1);
    xfer(io_space_pkg::OP_IN, 8'h58, 0, 0, 8'h00, 0);
    xfer(io_space_pkg::OP_LOAD, 8'h2C, 0, 0, 8'h00, 0);
    xfer(io_space_pkg::OP_LOAD, 8'h10, 0, 0, 8'h00, 0);
    xfer(io_space_pkg::OP_IN, 8'h00, 0, 0, 8'h00, 0);
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    check_byte(out_b, 8'h00);
    check_byte(fl_ex, 8'h00);
    @(posedge mclk_i);
    rst_n_i <= 1'b1;
    xfer(io_space_pkg::OP_LOAD, 8'h4A, 0, 0, 8'h00, 1);
    results();
  end
endmodule
`default_nettype wire
